// ### sdw_regs.sv
// supervisor register block: serial slave, diagnostic flags and watchdog configuration
//
// How it works
// - Config bit 0 picks 0.512 s or 32.768 s watchdog resolution.
// - Watchdog timeout is bits 7:1 times 0.512 s, times 64 if coarse.
// - Flags form a 24-bit word; low register bits 7:0, mid 15:8.
// - Low bit 0 sets at battery power-on reset, clears on read.
// - Low bit 1 sets on regulated undervoltage, clears on read.
// - Bits 2 and 3 set on overheat shutdown and warning, clear on read.
// - Low bit 4 sets on battery overvoltage, clears on read; bit 5 zero.
// - Low bit 6 sets on bus wakeup, clears on read.
// - Low bit 7 sets on window watchdog misuse, clears on read.
// - Mid bit 0 sets when transmit stays low over 1 s, clears on read.
// - Mid bit 1 sets on entering temporary shutdown, clears on read.
// - Mid bit 2 on timeout watchdog expiry, bit 3 load dump; clear on read.
// - Device is serial slave only; master frames transfers with chip select.
// - Trigger register bits 0 and 1 service watchdogs and self-clear quickly.
`include "sdw_consts.svh"
module sdw_regs #(
  parameter int P_TX_STUCK_CYCLES = `SDW_TX_STUCK_MS * `SDW_REF_CLK_KHZ,
  parameter int P_WD_TICK_CYCLES  = `SDW_WD_TICK_US / 1000 * `SDW_REF_CLK_KHZ
) (
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  // serial port
  input  wire logic               i_sclk,
  input  wire logic               i_serial_chip_select_n,
  input  wire logic               i_mosi,
  output logic                    o_miso,
  output logic                    o_miso_oe,
  // monitors
  input  wire sdw_pkg::sdw_sense_s i_sense
);
  import sdw_pkg::*;

  generate
    if (P_TX_STUCK_CYCLES < 2 || P_TX_STUCK_CYCLES > 16777215) begin : g_bad_tx
      $error("transmit stuck count out of range");
    end
  endgenerate

  localparam int SW = $bits(sdw_sense_s) + 3;
  // idle-high monitor levels, crossed inverted so a cleared synchroniser reads idle
  localparam sdw_sense_s SENSE_IDLE = '{transmit_level: 1'b1, default: 1'b0};

  typedef struct packed {
    logic        sclk_prev;
    logic [3:0]  bit_cnt;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic        is_read;
    logic [6:0]  addr;
    logic        miso;
    logic        miso_oe;
    logic [15:0] flags;
    logic [7:0]  wd_cfg;
    logic [1:0]  trig;
    logic        tshut_prev;
    logic [23:0] tx_low_cnt;
  } sdw_top_s;

  sdw_top_s       st_q;
  sdw_top_s       st_d;
  logic [SW-1:0]  sync_q;
  sdw_sense_s     sense_s;
  logic           sclk_s;
  logic           cs_n_s;
  logic           mosi_s;
  logic           win_fail;
  logic           to_fail;
  logic [15:0]    set_vec;
  logic [15:0]    clr_vec;
  logic [7:0]     rx_n;
  logic           rise;
  logic           fall;
  logic           wr_commit;
  sdw_diag_word_t diag_word;

  // ----------------------------------------------------------------------------
  // synchronisers for pins
  // ----------------------------------------------------------------------------
  sdw_sync2 #(
    .W (SW)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_d       ({i_sense ^ SENSE_IDLE, i_sclk, ~i_serial_chip_select_n, i_mosi}),
    .o_q       (sync_q)
  );

  // unpack synchronised levels; chip select and transmit level travel inverted,
  // so reset shows them idle instead of a false select or a stuck line
  assign sense_s = sync_q[SW-1:3] ^ SENSE_IDLE;
  assign sclk_s  = sync_q[2];
  assign cs_n_s  = ~sync_q[1];
  assign mosi_s  = sync_q[0];

  // ----------------------------------------------------------------------------
  // watchdogs
  // ----------------------------------------------------------------------------
  sdw_watchdog #(
    .P_TICK_CYCLES (P_WD_TICK_CYCLES)
  ) u_wd (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_cfg      (st_q.wd_cfg),
    .i_win_trig (st_q.trig[`SDW_TRIG_WIN_BIT]),
    .i_to_trig  (st_q.trig[`SDW_TRIG_TO_BIT]),
    .o_win_fail (win_fail),
    .o_to_fail  (to_fail)
  );

  // ----------------------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] read_byte(input logic [6:0] a, input sdw_top_s s);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `SDW_ADDR_DIAG_LOW: r = s.flags[7:0];
      `SDW_ADDR_DIAG_MID: r = s.flags[15:8];
      `SDW_ADDR_WD_CFG:   r = s.wd_cfg;
      default:            r = 8'h00;          // trigger, reserved, unmapped
    endcase
    return r;
  endfunction : read_byte

  // full diagnostic word, upper byte reserved
  assign diag_word = {8'h00, st_q.flags};

  // ----------------------------------------------------------------------------
  // flag set sources
  // ----------------------------------------------------------------------------
  always_comb begin
    set_vec                    = 16'h0000;
    set_vec[`SDW_FLG_POR]      = sense_s.battery_supply_power_on_reset;
    set_vec[`SDW_FLG_UV]       = sense_s.regulated_undervoltage;
    set_vec[`SDW_FLG_OT_SD]    = sense_s.overheat_shutdown;
    set_vec[`SDW_FLG_OT_WARN]  = sense_s.overheat_warning;
    set_vec[`SDW_FLG_OV]       = sense_s.battery_overvoltage;
    set_vec[`SDW_FLG_WAKE]     = sense_s.bus_wakeup;
    set_vec[`SDW_FLG_WD_WIN]   = win_fail;
    set_vec[`SDW_FLG_TX_STUCK] = (st_q.tx_low_cnt == 24'(P_TX_STUCK_CYCLES));
    set_vec[`SDW_FLG_TSHUT]    = sense_s.temporary_shutdown_state
                                 && !st_q.tshut_prev;
    set_vec[`SDW_FLG_WD_TO]    = to_fail;
    set_vec[`SDW_FLG_LDUMP]    = sense_s.load_dump;
  end

  // serial edges seen by the reference clock
  assign rise      = sclk_s && !st_q.sclk_prev;
  assign fall      = !sclk_s && st_q.sclk_prev;
  assign rx_n      = {st_q.rx[6:0], mosi_s};
  assign wr_commit = !cs_n_s && rise && (st_q.bit_cnt == 4'hF) && !st_q.is_read;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_d            = st_q;
    clr_vec         = 16'h0000;
    st_d.sclk_prev  = sclk_s;
    st_d.tshut_prev = sense_s.temporary_shutdown_state;
    st_d.trig       = 2'b00; // trigger bits live one cycle
    if (cs_n_s) begin
      // frame closed: port idles and releases the data line
      st_d.bit_cnt = 4'h0;
      st_d.tx      = 8'h00;
      st_d.miso    = 1'b0;
      st_d.miso_oe = 1'b0;
    end else begin
      st_d.miso_oe = 1'b1;
      if (rise) begin
        st_d.rx      = rx_n;
        st_d.bit_cnt = st_q.bit_cnt + 4'h1;
        if (st_q.bit_cnt == 4'h7) begin
          // header complete: direction bit then address
          st_d.is_read = rx_n[7];
          st_d.addr    = rx_n[6:0];
          if (rx_n[7]) begin
            st_d.tx = read_byte(rx_n[6:0], st_q);
            if (rx_n[6:0] == `SDW_ADDR_DIAG_LOW) begin
              clr_vec[7:0] = 8'hFF;
            end
            if (rx_n[6:0] == `SDW_ADDR_DIAG_MID) begin
              clr_vec[15:8] = 8'hFF;
            end
          end
        end
        if (wr_commit) begin
          case (st_q.addr)
            `SDW_ADDR_WD_CFG:  st_d.wd_cfg = rx_n;
            `SDW_ADDR_WD_TRIG: st_d.trig   = rx_n[1:0];
            default:           st_d.wd_cfg = st_q.wd_cfg;   // read-only or unmapped
          endcase
        end
      end
      if (fall) begin
        // shift read data out msb first on falling edges
        st_d.miso = st_q.tx[7];
        st_d.tx   = {st_q.tx[6:0], 1'b0};
      end
    end
    // transmit-low timer saturates at its limit
    if (sense_s.transmit_level) begin
      st_d.tx_low_cnt = 24'h000000;
    end else if (st_q.tx_low_cnt != 24'(P_TX_STUCK_CYCLES)) begin
      st_d.tx_low_cnt = st_q.tx_low_cnt + 24'h000001;
    end
    // a new event wins over the clearing read
    st_d.flags = (st_q.flags & ~clr_vec) | set_vec;
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_q       <= '0;
      st_q.flags <= {`SDW_RST_DIAG_MID, `SDW_RST_DIAG_LOW};
      st_q.wd_cfg <= `SDW_RST_WD_CFG;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops
  assign o_miso    = st_q.miso;
  assign o_miso_oe = st_q.miso_oe;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  chk_cfg_write_lands: assert property (wr_commit && st_q.addr == `SDW_ADDR_WD_CFG
    |=> st_q.wd_cfg == $past(rx_n))
    else $error("watchdog configuration write lost");

  chk_trig_self_clear: assert property (st_q.trig != 2'b00 |=> st_q.trig == 2'b00)
    else $error("trigger bit did not self-clear");

  chk_set_beats_clear: assert property (clr_vec[`SDW_FLG_UV] && set_vec[`SDW_FLG_UV]
    |=> st_q.flags[`SDW_FLG_UV])
    else $error("event lost in clearing read");

  chk_uv_sticky_set: assert property (sense_s.regulated_undervoltage
    |=> st_q.flags[`SDW_FLG_UV] ##1 (st_q.flags[`SDW_FLG_UV] || $past(clr_vec[1])))
    else $error("undervoltage flag not held");

  chk_por_read_clear: assert property (clr_vec[0] && !set_vec[0] |=> !st_q.flags[0])
    else $error("power-on flag not cleared by read");

  chk_reserved_zero: assert property (!st_q.flags[5] && st_q.flags[15:12] == 4'h0
    && diag_word[23:16] == 8'h00)
    else $error("reserved flag bit set");

  chk_port_release: assert property (cs_n_s ##1 cs_n_s |-> !o_miso_oe && !o_miso)
    else $error("data line driven outside frame");

  chk_tx_stuck_flag: assert property (!sense_s.transmit_level [*2] ##0
    st_q.tx_low_cnt == 24'(P_TX_STUCK_CYCLES - 1) |=> ##1 st_q.flags[`SDW_FLG_TX_STUCK])
    else $error("transmit stuck flag missing");

  chk_wd_fail_flag: assert property (win_fail || to_fail |=>
    (st_q.flags[`SDW_FLG_WD_WIN] || st_q.flags[`SDW_FLG_WD_TO]))
    else $error("watchdog failure not flagged");

  chk_read_byte_low: assert property (rise && !cs_n_s && st_q.bit_cnt == 4'h7 && rx_n[7]
    && rx_n[6:0] == `SDW_ADDR_DIAG_LOW |=> st_q.tx == $past(st_q.flags[7:0]))
    else $error("low diagnostic byte not loaded");

  cov_read_diag:  cover property (clr_vec[7:0] == 8'hFF);
  cov_write_cfg:  cover property (wr_commit && st_q.addr == `SDW_ADDR_WD_CFG);
  cov_trigger:    cover property (st_q.trig[`SDW_TRIG_TO_BIT]);
  cov_tx_stuck:   cover property (set_vec[`SDW_FLG_TX_STUCK]);

endmodule : sdw_regs

// ### sdw_consts.svh
// offsets, field positions, reset values and timing counts of the supervisor register block
`ifndef SDW_CONSTS_SVH
`define SDW_CONSTS_SVH

// ----------------------------------------------------------------------------
// register addresses (7-bit serial address field)
// ----------------------------------------------------------------------------
`define SDW_ADDR_WD_TRIG   7'h06
`define SDW_ADDR_DIAG_LOW  7'h08
`define SDW_ADDR_DIAG_MID  7'h09
`define SDW_ADDR_WD_CFG    7'h0E
`define SDW_ADDR_RSVD_F    7'h0F

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SDW_RST_DIAG_LOW   8'h03
`define SDW_RST_DIAG_MID   8'h00
`define SDW_RST_WD_CFG     8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SDW_CFG_RES_BIT    0
`define SDW_TRIG_WIN_BIT   0
`define SDW_TRIG_TO_BIT    1
`define SDW_FLG_POR        0
`define SDW_FLG_UV         1
`define SDW_FLG_OT_SD      2
`define SDW_FLG_OT_WARN    3
`define SDW_FLG_OV         4
`define SDW_FLG_WAKE       6
`define SDW_FLG_WD_WIN     7
`define SDW_FLG_TX_STUCK   8
`define SDW_FLG_TSHUT      9
`define SDW_FLG_WD_TO      10
`define SDW_FLG_LDUMP      11

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SDW_REF_CLK_KHZ    10000
`define SDW_TX_STUCK_MS    1000
`define SDW_WD_TICK_US     512000
`define SDW_WD_RES_MULT    64

`endif

// ### sdw_pkg.sv
// types shared by the supervisor register block
package sdw_pkg;

  // analog and bus monitor inputs, all asynchronous to i_ref_clk
  typedef struct packed {
    logic battery_supply_power_on_reset;
    logic regulated_undervoltage;
    logic overheat_shutdown;
    logic overheat_warning;
    logic battery_overvoltage;
    logic bus_wakeup;
    logic transmit_level;
    logic temporary_shutdown_state;
    logic load_dump;
  } sdw_sense_s;

  // 24-bit diagnostic word; bits 23:16 are not held here and read as zero
  typedef logic [23:0] sdw_diag_word_t;

endpackage : sdw_pkg

// ### sdw_sync2.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
module sdw_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset,
  // levels
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sdw_sync_s;

  sdw_sync_s st_q;
  sdw_sync_s st_d;

  // ----------------------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------------------
  // first stage feeds only the second
  always_comb begin
    st_d      = st_q;
    st_d.meta = i_d;
    st_d.q    = st_q.meta;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_q = st_q.q;

endmodule : sdw_sync2

// ### sdw_watchdog.sv
// window and timeout watchdogs timed from the timeout configuration register
`include "sdw_consts.svh"
module sdw_watchdog #(
  parameter int P_TICK_CYCLES = `SDW_WD_TICK_US / 1000 * `SDW_REF_CLK_KHZ
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // configuration and triggers
  input  wire logic [7:0] i_cfg,
  input  wire logic       i_win_trig,
  input  wire logic       i_to_trig,
  // failure pulses
  output logic            o_win_fail,
  output logic            o_to_fail
);

  generate
    if (P_TICK_CYCLES < 1 || P_TICK_CYCLES > 8388608) begin : g_bad_tick
      $error("tick count out of range");
    end
  endgenerate

  typedef struct packed {
    logic [22:0] presc;
    logic [12:0] win_cnt;
    logic [12:0] to_cnt;
    logic        win_fail;
    logic        to_fail;
  } sdw_wd_s;

  sdw_wd_s     st_q;
  sdw_wd_s     st_d;
  logic [12:0] limit;
  logic        tick;
  logic        en;

  // ----------------------------------------------------------------------------
  // timeout in ticks of 0.512 s, scaled by 64 at coarse resolution
  // ----------------------------------------------------------------------------
  assign limit = i_cfg[`SDW_CFG_RES_BIT] ? 13'(i_cfg[7:1]) * 13'(`SDW_WD_RES_MULT)
                                         : 13'(i_cfg[7:1]);
  assign en    = (i_cfg[7:1] != 7'h00);
  assign tick  = (st_q.presc == 23'(P_TICK_CYCLES - 1));

  // counters restart on a trigger and on every failure
  always_comb begin
    st_d          = st_q;
    st_d.win_fail = 1'b0;
    st_d.to_fail  = 1'b0;
    st_d.presc    = tick ? 23'h000000 : st_q.presc + 23'h000001;
    if (i_to_trig) begin
      st_d.to_cnt = 13'h0000;
    end else if (tick && en) begin
      if (st_q.to_cnt + 13'h0001 >= limit) begin
        st_d.to_fail = 1'b1;
        st_d.to_cnt  = 13'h0000;
      end else begin
        st_d.to_cnt = st_q.to_cnt + 13'h0001;
      end
    end
    if (i_win_trig) begin
      st_d.win_fail = en && (st_q.win_cnt < (limit >> 1)); // early trigger
      st_d.win_cnt  = 13'h0000;
    end else if (tick && en) begin
      if (st_q.win_cnt + 13'h0001 >= limit) begin
        st_d.win_fail = 1'b1; // missed trigger
        st_d.win_cnt  = 13'h0000;
      end else begin
        st_d.win_cnt = st_q.win_cnt + 13'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_win_fail = st_q.win_fail;
  assign o_to_fail  = st_q.to_fail;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  chk_fine_res_limit: assert property (!i_cfg[0] |-> limit == {6'h00, i_cfg[7:1]})
    else $error("fine resolution limit wrong");
  chk_coarse_res_limit: assert property (i_cfg[0] |-> limit == {i_cfg[7:1], 6'h00})
    else $error("coarse resolution limit wrong");
  chk_timeout_expiry: assert property (tick && en && !i_to_trig && st_q.to_cnt == limit - 13'h0001
    |=> o_to_fail ##1 !o_to_fail)
    else $error("timeout watchdog did not fail at limit");
  cov_timeout_fail: cover property (o_to_fail);

endmodule : sdw_watchdog

// ### sdw_mcu_model.sv
// microcontroller model: serial bus master of the supervisor register block
module sdw_mcu_model (
  // clock
  input  wire logic i_ref_clk,
  // serial port
  input  wire logic i_miso,
  output logic      o_sclk,
  output logic      o_serial_chip_select_n,
  output logic      o_mosi
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------------------
  // clock parked low, nothing selected
  initial begin
    o_sclk                 = 1'b0;
    o_serial_chip_select_n = 1'b1;
    o_mosi                 = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // frame
  // ---------------------------------------------------------------------------
  // nbits msb first, mode 0, 800 ns bit time; rd collects the bits of the data byte
  task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge i_ref_clk);
    o_serial_chip_select_n <= 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      @(posedge i_ref_clk);
      o_mosi <= frame[i];
      repeat (3) @(posedge i_ref_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      // sampled late in the high phase, where the slave output is settled
      if (i < 8) begin
        rd = {rd[6:0], i_miso};
      end
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_ref_clk);
    o_serial_chip_select_n <= 1'b1;
    o_mosi                 <= ~o_mosi; // released line does not keep its value
    repeat (8) @(posedge i_ref_clk);
  endtask : xfer

endmodule : sdw_mcu_model

// ### sdw_regs_tb.sv
// self-checking testbench of the supervisor register block
`include "sdw_consts.svh"
module sdw_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sdw_pkg::*;

  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic       ref_clk;
  logic       reset;
  logic       sclk;
  logic       cs_n;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  sdw_sense_s sense;
  logic [7:0] junk;
  int         n_mismatch      = 0;
  int         samples_checked = 0;

  // flag sources (bit of sense), register and expected byte
  int         flag_sel [8] = '{8, 7, 6, 5, 4, 3, 1, 0};
  logic [6:0] flag_reg [8] = '{`SDW_ADDR_DIAG_LOW, `SDW_ADDR_DIAG_LOW, `SDW_ADDR_DIAG_LOW,
                               `SDW_ADDR_DIAG_LOW, `SDW_ADDR_DIAG_LOW, `SDW_ADDR_DIAG_LOW,
                               `SDW_ADDR_DIAG_MID, `SDW_ADDR_DIAG_MID};
  logic [7:0] flag_val [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h02, 8'h08};

  // ---------------------------------------------------------------------------
  // design and partner
  // ---------------------------------------------------------------------------
  sdw_regs #(
    .P_TX_STUCK_CYCLES (50),
    .P_WD_TICK_CYCLES  (20)
  ) dut_u (
    .i_ref_clk              (ref_clk),
    .i_reset                (reset),
    .i_sclk                 (sclk),
    .i_serial_chip_select_n (cs_n),
    .i_mosi                 (mosi),
    .o_miso                 (miso),
    .o_miso_oe              (miso_oe),
    .i_sense                (sense)
  );

  sdw_mcu_model mcu_u (
    .i_ref_clk              (ref_clk),
    .i_miso                 (miso),
    .o_sclk                 (sclk),
    .o_serial_chip_select_n (cs_n),
    .o_mosi                 (mosi)
  );

  // 10 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  // masked byte compare
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
    samples_checked++;
    if ((got & mask) !== (exp & mask)) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] v;
    mcu_u.xfer({1'b1, a, 8'h00}, 16, v);
    check8(v, exp, mask);
  endtask : rd_chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    mcu_u.xfer({1'b0, a, d}, 16, v);
  endtask : wr

  // invert one monitor input for n cycles
  task automatic pulse(input int k, input int n);
    @(posedge ref_clk);
    sense[k] <= ~sense[k];
    repeat (n) @(posedge ref_clk);
    sense[k] <= ~sense[k];
    repeat (4) @(posedge ref_clk);
  endtask : pulse

  task automatic wrap_up;
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // hang guard, about three times the expected run
  initial begin
    #3000000;
    n_mismatch++;
    wrap_up();
  end

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    sense = sdw_sense_s'(9'h004); // transmit line idles high
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check8({6'h00, miso_oe, miso}, 8'h00, 8'hFF);
    // reset values, then clear on read
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h03, 8'hFF);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h00, 8'hFF);
    rd_chk(`SDW_ADDR_WD_CFG, 8'h00, 8'hFF);
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h00, 8'hFF);
    // each flag of the table: set by its event, sticky, cleared by the first read
    for (int j = 0; j < 8; j++) begin
      pulse(flag_sel[j], 6);
      rd_chk(flag_reg[j], flag_val[j], 8'hFF);
      rd_chk(flag_reg[j], 8'h00, 8'hFF);
    end
    // undervoltage held through a clearing read: the event wins
    sense[7] <= 1'b1;
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h02, 8'hFF);
    sense[7] <= 1'b0;
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h02, 8'hFF);
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h00, 8'hFF);
    // transmit low just under and well over the stuck limit
    pulse(2, 40);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h00, 8'hFF);
    pulse(2, 70);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h01, 8'hFF);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h00, 8'hFF);
    // configuration write, aborted frame, refused and empty places
    wr(`SDW_ADDR_WD_CFG, 8'hA5);
    rd_chk(`SDW_ADDR_WD_CFG, 8'hA5, 8'hFF);
    mcu_u.xfer({1'b0, `SDW_ADDR_WD_CFG, 8'h3C}, 10, junk);
    rd_chk(`SDW_ADDR_WD_CFG, 8'hA5, 8'hFF);
    wr(`SDW_ADDR_DIAG_LOW, 8'hFF);
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h00, 8'hFF);
    rd_chk(`SDW_ADDR_RSVD_F, 8'h00, 8'hFF);
    rd_chk(7'h20, 8'h00, 8'hFF);
    rd_chk(`SDW_ADDR_WD_TRIG, 8'h00, 8'hFF);
    // fine resolution, field 1: both watchdogs expire untriggered
    wr(`SDW_ADDR_WD_CFG, 8'h02);
    repeat (100) @(posedge ref_clk);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h04, 8'h04);
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h80, 8'h80);
    // coarse resolution, field 1: 1280 cycles to expiry
    wr(`SDW_ADDR_WD_CFG, 8'h03);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h04, 8'h04);
    repeat (500) @(posedge ref_clk);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h00, 8'h04);
    repeat (800) @(posedge ref_clk);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h04, 8'h04);
    // field 30: window opens after 300 cycles, expiry at 600
    wr(`SDW_ADDR_WD_CFG, 8'h3C);
    wr(`SDW_ADDR_WD_TRIG, 8'h03);
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h80, 8'h80);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h04, 8'h04);
    wr(`SDW_ADDR_WD_TRIG, 8'h03);
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h00, 8'h80);
    rd_chk(`SDW_ADDR_DIAG_MID, 8'h00, 8'h04);
    wr(`SDW_ADDR_WD_TRIG, 8'h03);
    // early trigger inside the closed window
    wr(`SDW_ADDR_WD_TRIG, 8'h03);
    rd_chk(`SDW_ADDR_DIAG_LOW, 8'h80, 8'h80);
    rd_chk(`SDW_ADDR_WD_TRIG, 8'h00, 8'hFF);
    wrap_up();
  end

endmodule : sdw_regs_tb
